// ===== mad_pkg.sv
// Package for the motion activity/inactivity detector: constants, modes and carriers
`default_nettype none
package mad_pkg;
    localparam int SAMPLE_W = 16;
    localparam int TIMER_W = 16;
    localparam int N_AXES = 3;
    // Operating mode codes on the 4-bit mode port
    localparam logic [3:0] OPM_STANDBY = 4'h0;
    localparam logic [3:0] OPM_HEART_SOUND = 4'h1;
    localparam logic [3:0] OPM_ULTRA_LOW_POWER = 4'h2;
    localparam logic [3:0] OPM_VERY_LOW_POWER = 4'h3;
    // Longest activity filter, in seconds, and fastest motion sample rate in Hz
    localparam int ACT_TIME_MAX_S = 20;
    localparam int MOTION_ODR_MAX_HZ = 500;
    localparam int ACT_TIME_MAX_SAMPLES = ACT_TIME_MAX_S * MOTION_ODR_MAX_HZ;
    localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;
    localparam logic [SAMPLE_W-1:0] THRESH_RST = 16'h0000;

    typedef enum logic [1:0] {
        MAD_LINK_DEFAULT,
        MAD_LINK_LINKED,
        MAD_LINK_LOOP,
        MAD_LINK_RSVD
    } mad_link_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] x;
        logic [SAMPLE_W-1:0] y;
        logic [SAMPLE_W-1:0] z;
    } mad_sample_t;

    typedef struct packed {
        logic enable;
        logic referenced;
        logic [N_AXES-1:0] axis_en;
        logic [SAMPLE_W-1:0] thresh;
        logic [TIMER_W-1:0] time_cnt;
    } mad_det_cfg_t;
endpackage
`default_nettype wire

// ===== mad_timer.sv
// Consecutive-sample timer for one detector
`timescale 1ns/10ps
`default_nettype none
module mad_timer #(
    parameter int TIMER_W = 16
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic qual_i,
    input wire logic [TIMER_W-1:0] limit_i,
    output logic fire_o
);
    logic [TIMER_W-1:0] cnt_ff;
    logic [TIMER_W-1:0] nxt_cnt;
    logic fire_ff;
    logic nxt_fire;

    if (TIMER_W < 1 || TIMER_W > 31) begin : g_bad_width
        $error("mad_timer: bad TIMER_W");
    end

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_fire = 1'b0;
        if (clear_i) begin
            nxt_cnt = '0;
        end else if (step_i) begin
            if (!qual_i) begin
                nxt_cnt = '0;
            end else if ({1'b0, cnt_ff} + 1'b1 > {1'b0, limit_i}) begin
                // Limit zero means a single sample suffices
                nxt_fire = 1'b1;
                nxt_cnt = '0;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_ff <= '0;
            fire_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            fire_ff <= nxt_fire;
        end
    end

    assign fire_o = fire_ff;
endmodule
`default_nettype wire

// ===== mad_detector.sv
// Activity/inactivity detection with reference tracking and link modes
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Referenced activity needs |accel - reference| above threshold for the set time.
// - Activity reference recaptured at enable, link re-arm, or unlinked repeat.
// - Activity filter spans one sample up to 20 seconds; short bursts ignored.
// - Inactivity needs every enabled axis below threshold for the set time.
// - Absolute inactivity compares raw samples over consecutive sample count.
// - Referenced inactivity sample is quiet when |accel - reference| below threshold.
// - Inactivity reference captured at start and at each inactivity event only.
// - First measurement uses absolute compare until a reference is captured.
// - Both detectors disabled after reset until host enables them.
// - Default mode runs both; each flag holds until host reads it.
// - Linked mode runs one detector at a time, alternating after events.
// - Linked mode arms activity first; next armed after host service.
// - Loop mode alternates and clears events itself, no host service.
// - Activity when any enabled axis exceeds threshold; disabled axes ignored.
// - Absolute activity compares raw sample magnitudes against threshold.
// - Events set status flags outside loop mode, each optionally routed to interrupt output.
// - Detection works only in very-low, ultra-low power and heart sound modes.
module mad_detector
    import mad_pkg::*;
#(
    parameter int AXES = mad_pkg::N_AXES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] op_mode_i,
    input wire mad_pkg::mad_link_t link_mode_i,
    input wire mad_pkg::mad_det_cfg_t act_cfg_i,
    input wire mad_pkg::mad_det_cfg_t inact_cfg_i,
    input wire logic sample_valid_i,
    input wire mad_pkg::mad_sample_t sample_i,
    input wire logic act_read_i,
    input wire logic inact_read_i,
    input wire logic act_int_map_i,
    input wire logic inact_int_map_i,
    output logic act_flag_o,
    output logic inact_flag_o,
    output logic act_armed_o,
    output logic inact_armed_o,
    output logic motion_int_o
);
    import mad_pkg::*;

    // The timer must hold the longest activity filter without wrapping
    if (AXES != N_AXES || (2 ** TIMER_W) <= ACT_TIME_MAX_SAMPLES) begin : g_bad_cfg
        $error("mad_detector: unsupported axis count or timer width");
    end

    // ****************************************
    // Mode and sample qualification
    // ****************************************
    logic motion_mode;
    logic measuring;
    logic step;
    logic [SAMPLE_W-1:0] axis_val [AXES];

    assign motion_mode = (op_mode_i == OPM_VERY_LOW_POWER) ||
                         (op_mode_i == OPM_ULTRA_LOW_POWER) ||
                         (op_mode_i == OPM_HEART_SOUND);
    assign measuring = (op_mode_i != OPM_STANDBY);
    assign step = sample_valid_i && motion_mode;
    assign axis_val[0] = sample_i.x;
    assign axis_val[1] = sample_i.y;
    assign axis_val[2] = sample_i.z;

    // ****************************************
    // State registers
    // ****************************************
    mad_sample_t act_ref_ff, nxt_act_ref;
    mad_sample_t inact_ref_ff, nxt_inact_ref;
    logic act_ref_ok_ff, nxt_act_ref_ok;
    logic inact_ref_ok_ff, nxt_inact_ref_ok;
    logic act_flag_ff, nxt_act_flag;
    logic inact_flag_ff, nxt_inact_flag;
    logic act_arm_ff, nxt_act_arm;
    logic inact_arm_ff, nxt_inact_arm;
    logic meas_d_ff, nxt_meas_d;
    logic act_en_d_ff, nxt_act_en_d;
    logic inact_en_d_ff, nxt_inact_en_d;
    logic act_reref_ff, nxt_act_reref;
    logic int_ff, nxt_int;

    // ****************************************
    // Per-axis comparisons
    // ****************************************
    logic [AXES-1:0] act_hit;
    logic [AXES-1:0] inact_quiet;
    logic [SAMPLE_W-1:0] act_ref_v [AXES];
    logic [SAMPLE_W-1:0] inact_ref_v [AXES];
    assign act_ref_v[0] = act_ref_ff.x;
    assign act_ref_v[1] = act_ref_ff.y;
    assign act_ref_v[2] = act_ref_ff.z;
    assign inact_ref_v[0] = inact_ref_ff.x;
    assign inact_ref_v[1] = inact_ref_ff.y;
    assign inact_ref_v[2] = inact_ref_ff.z;

    // Signed samples; magnitude computed one bit wider so full-scale swings do not wrap
    function automatic logic [SAMPLE_W:0] mag(input logic [SAMPLE_W:0] v);
        mag = v[SAMPLE_W] ? (~v + 1'b1) : v;
    endfunction

    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            logic [SAMPLE_W:0] raw;
            logic [SAMPLE_W:0] a_dev;
            logic [SAMPLE_W:0] i_dev;
            logic [SAMPLE_W:0] a_cmp;
            logic [SAMPLE_W:0] i_cmp;
            assign raw = {axis_val[g][SAMPLE_W-1], axis_val[g]};
            assign a_dev = raw - {act_ref_v[g][SAMPLE_W-1], act_ref_v[g]};
            assign i_dev = raw - {inact_ref_v[g][SAMPLE_W-1], inact_ref_v[g]};
            // Referenced compare only once a reference exists
            assign a_cmp = (act_cfg_i.referenced && act_ref_ok_ff) ?
                           mag(a_dev) : mag(raw);
            assign i_cmp = (inact_cfg_i.referenced && inact_ref_ok_ff) ?
                           mag(i_dev) : mag(raw);
            assign act_hit[g] = act_cfg_i.axis_en[g] &&
                                (a_cmp > {1'b0, act_cfg_i.thresh});
            assign inact_quiet[g] = !inact_cfg_i.axis_en[g] ||
                                    (i_cmp < {1'b0, inact_cfg_i.thresh});
        end
    endgenerate

    // ****************************************
    // Timers
    // ****************************************
    logic act_run;
    logic inact_run;
    logic act_fire;
    logic inact_fire;
    logic linking;

    assign linking = (link_mode_i == MAD_LINK_LINKED) || (link_mode_i == MAD_LINK_LOOP);
    // A held flag blocks re-firing in default mode; armed state gates linked modes
    assign act_run = act_cfg_i.enable && !act_flag_ff && (!linking || act_arm_ff);
    assign inact_run = inact_cfg_i.enable && !inact_flag_ff &&
                       (!linking || inact_arm_ff);

    mad_timer #(.TIMER_W(TIMER_W)) u_act_timer (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!act_run),
        .step_i(step),
        .qual_i(|act_hit),
        .limit_i(act_cfg_i.time_cnt),
        .fire_o(act_fire)
    );

    mad_timer #(.TIMER_W(TIMER_W)) u_inact_timer (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(!inact_run),
        .step_i(step),
        .qual_i(&inact_quiet),
        .limit_i(inact_cfg_i.time_cnt),
        .fire_o(inact_fire)
    );

    // ****************************************
    // Event, arming and reference control
    // ****************************************
    always_comb begin
        nxt_act_ref = act_ref_ff;
        nxt_inact_ref = inact_ref_ff;
        nxt_act_ref_ok = act_ref_ok_ff;
        nxt_inact_ref_ok = inact_ref_ok_ff;
        nxt_act_flag = act_flag_ff;
        nxt_inact_flag = inact_flag_ff;
        nxt_act_arm = act_arm_ff;
        nxt_inact_arm = inact_arm_ff;
        nxt_meas_d = measuring;
        nxt_act_en_d = act_cfg_i.enable;
        nxt_inact_en_d = inact_cfg_i.enable;
        nxt_act_reref = act_reref_ff;

        // Host read clears; a same-cycle event wins below
        if (act_read_i && link_mode_i != MAD_LINK_LOOP) begin
            nxt_act_flag = 1'b0;
            if (link_mode_i == MAD_LINK_LINKED && act_flag_ff) begin
                nxt_inact_arm = 1'b1;
            end
        end
        if (inact_read_i && link_mode_i != MAD_LINK_LOOP) begin
            nxt_inact_flag = 1'b0;
            if (link_mode_i == MAD_LINK_LINKED && inact_flag_ff) begin
                nxt_act_arm = 1'b1;
                nxt_act_reref = 1'b1;
            end
        end

        if (act_fire) begin
            nxt_act_flag = (link_mode_i != MAD_LINK_LOOP);
            nxt_act_arm = 1'b0;
            if (link_mode_i == MAD_LINK_LOOP) begin
                nxt_inact_arm = 1'b1;
            end
            if (!linking) begin
                nxt_act_reref = 1'b1;
            end
        end
        if (inact_fire) begin
            nxt_inact_flag = (link_mode_i != MAD_LINK_LOOP);
            nxt_inact_arm = 1'b0;
            nxt_inact_ref = sample_i;
            nxt_inact_ref_ok = 1'b1;
            if (link_mode_i == MAD_LINK_LOOP) begin
                nxt_act_arm = 1'b1;
                nxt_act_reref = 1'b1;
            end
        end

        // Pending activity recapture taken on the next sample once detection resumes
        if (act_reref_ff && step && act_run && !act_fire) begin
            nxt_act_ref = sample_i;
            nxt_act_ref_ok = 1'b1;
            nxt_act_reref = 1'b0;
        end

        // Entering measurement or switching a function on starts fresh
        if ((measuring && !meas_d_ff) || (act_cfg_i.enable && !act_en_d_ff)) begin
            nxt_act_ref_ok = 1'b0;
            nxt_act_reref = 1'b1;
        end
        if ((measuring && !meas_d_ff) || (inact_cfg_i.enable && !inact_en_d_ff)) begin
            nxt_inact_ref_ok = 1'b0;
        end
        if (inact_cfg_i.enable && !inact_ref_ok_ff && step && !inact_fire &&
            !(measuring && !meas_d_ff)) begin
            nxt_inact_ref = sample_i;
            nxt_inact_ref_ok = 1'b1;
        end

        // Standby reloads the linked start point: activity first
        if (!measuring) begin
            nxt_act_arm = 1'b1;
            nxt_inact_arm = 1'b0;
        end

        nxt_int = (nxt_act_flag && act_int_map_i) || (nxt_inact_flag && inact_int_map_i);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            act_ref_ff <= '0;
            inact_ref_ff <= '0;
            act_ref_ok_ff <= 1'b0;
            inact_ref_ok_ff <= 1'b0;
            act_flag_ff <= 1'b0;
            inact_flag_ff <= 1'b0;
            act_arm_ff <= 1'b1;
            inact_arm_ff <= 1'b0;
            meas_d_ff <= 1'b0;
            act_en_d_ff <= 1'b0;
            inact_en_d_ff <= 1'b0;
            act_reref_ff <= 1'b0;
            int_ff <= 1'b0;
        end else begin
            act_ref_ff <= nxt_act_ref;
            inact_ref_ff <= nxt_inact_ref;
            act_ref_ok_ff <= nxt_act_ref_ok;
            inact_ref_ok_ff <= nxt_inact_ref_ok;
            act_flag_ff <= nxt_act_flag;
            inact_flag_ff <= nxt_inact_flag;
            act_arm_ff <= nxt_act_arm;
            inact_arm_ff <= nxt_inact_arm;
            meas_d_ff <= nxt_meas_d;
            act_en_d_ff <= nxt_act_en_d;
            inact_en_d_ff <= nxt_inact_en_d;
            act_reref_ff <= nxt_act_reref;
            int_ff <= nxt_int;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign act_flag_o = act_flag_ff;
    assign inact_flag_o = inact_flag_ff;
    assign act_armed_o = act_arm_ff;
    assign inact_armed_o = inact_arm_ff;
    assign motion_int_o = int_ff;
endmodule
`default_nettype wire

// ===== mad_detector_properties.sv
// Concurrent checks on the motion detector ports
`timescale 1ns/10ps
`default_nettype none
module mad_detector_properties
    import mad_pkg::*;
#(
    parameter int AXES = mad_pkg::N_AXES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] op_mode_i,
    input wire mad_pkg::mad_link_t link_mode_i,
    input wire mad_pkg::mad_det_cfg_t act_cfg_i,
    input wire mad_pkg::mad_det_cfg_t inact_cfg_i,
    input wire logic sample_valid_i,
    input wire mad_pkg::mad_sample_t sample_i,
    input wire logic act_read_i,
    input wire logic inact_read_i,
    input wire logic act_int_map_i,
    input wire logic inact_int_map_i,
    input wire logic act_flag_o,
    input wire logic inact_flag_o,
    input wire logic act_armed_o,
    input wire logic inact_armed_o,
    input wire logic motion_int_o
);
    // ****************************************
    // Port relations
    // ****************************************
    logic motion_mode;
    assign motion_mode = op_mode_i inside {OPM_HEART_SOUND, OPM_ULTRA_LOW_POWER,
                                           OPM_VERY_LOW_POWER};
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence link_svc_s;
        link_mode_i == MAD_LINK_LINKED && op_mode_i != OPM_STANDBY && act_flag_o && act_read_i
            ##1 !act_flag_o;
    endsequence
    rst_state_a: assert property (disable iff (1'b0) sys_rst_i |=>
        !act_flag_o && !inact_flag_o && !motion_int_o && act_armed_o && !inact_armed_o)
        else $error("reset state wrong");
    act_cause_a: assert property ($rose(act_flag_o) |-> $past(sample_valid_i, 2)
        && $past(act_cfg_i.enable, 2) && $past(motion_mode, 2))
        else $error("activity flag without enabled motion sample");
    inact_cause_a: assert property ($rose(inact_flag_o) |-> $past(sample_valid_i, 2)
        && $past(inact_cfg_i.enable, 2) && $past(motion_mode, 2))
        else $error("inactivity flag without enabled motion sample");
    int_map_a: assert property (motion_int_o == ((act_flag_o && $past(act_int_map_i))
        || (inact_flag_o && $past(inact_int_map_i))))
        else $error("interrupt does not follow mapped flags");
    read_clear_a: assert property (act_flag_o && act_read_i && link_mode_i != MAD_LINK_LOOP
        && !$past(sample_valid_i) |=> !act_flag_o)
        else $error("host read did not clear activity flag");
    loop_quiet_a: assert property (link_mode_i == MAD_LINK_LOOP |->
        !$rose(act_flag_o) && !$rose(inact_flag_o))
        else $error("flag raised in loop mode");
    standby_arm_a: assert property (op_mode_i == OPM_STANDBY |=>
        act_armed_o && !inact_armed_o)
        else $error("standby did not rearm activity");
    link_excl_a: assert property (link_mode_i inside {MAD_LINK_LINKED, MAD_LINK_LOOP}
        && $past(link_mode_i) == link_mode_i |-> !(act_armed_o && inact_armed_o))
        else $error("both detectors armed while linked");
    link_svc_a: assert property (link_svc_s |-> inact_armed_o && !act_armed_o)
        else $error("service did not arm inactivity");
endmodule
`default_nettype wire

// ===== mad_host_model.sv
// Host that services detector flags after a programmable delay
`timescale 1ns/10ps
`default_nettype none
module mad_host_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic svc_en_i,
    input wire logic [3:0] delay_i,
    input wire logic act_flag_i,
    input wire logic inact_flag_i,
    output logic act_read_o,
    output logic inact_read_o
);
    // ****************************************
    // Service loop
    // ****************************************
    logic [3:0] wait_ff;
    // One pulse per flag, then a fresh wait, so a flag is never read twice
    always_ff @(posedge clk_i) begin
        act_read_o <= 1'h0;
        inact_read_o <= 1'h0;
        if (sys_rst_i || !svc_en_i || !(act_flag_i || inact_flag_i) ||
            act_read_o || inact_read_o) begin
            wait_ff <= 4'h0;
        end else if (wait_ff == delay_i) begin
            act_read_o <= act_flag_i;
            inact_read_o <= inact_flag_i;
            wait_ff <= 4'h0;
        end else begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tb_mad_detector.sv
// Self-checking bench for the motion detector with a servicing host
`timescale 1ns/10ps
`default_nettype none
module tb_mad_detector;
    import mad_pkg::*;
    logic clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic [3:0] op_mode_i = OPM_STANDBY;
    mad_link_t link_mode_i = MAD_LINK_DEFAULT;
    mad_det_cfg_t act_cfg_i = '0;
    mad_det_cfg_t inact_cfg_i = '0;
    logic sample_valid_i = 1'h0;
    mad_sample_t sample_i = '0;
    logic act_int_map_i = 1'h1;
    logic inact_int_map_i = 1'h0;
    logic svc_en = 1'h0;
    logic [3:0] svc_dly = 4'h0;
    logic act_read_i, inact_read_i, act_flag_o, inact_flag_o, act_armed_o, inact_armed_o;
    logic motion_int_o;
    logic act_q = 1'h0;
    logic inact_q = 1'h0;
    logic [1:0] exp_q[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 32'h68c50a93;
    mad_detector dut_u (.clk_i, .sys_rst_i, .op_mode_i, .link_mode_i, .act_cfg_i, .inact_cfg_i,
        .sample_valid_i, .sample_i, .act_read_i, .inact_read_i, .act_int_map_i,
        .inact_int_map_i, .act_flag_o, .inact_flag_o, .act_armed_o, .inact_armed_o,
        .motion_int_o);
    mad_host_model host_u (.clk_i, .sys_rst_i, .svc_en_i(svc_en), .delay_i(svc_dly),
        .act_flag_i(act_flag_o), .inact_flag_i(inact_flag_o), .act_read_o(act_read_i),
        .inact_read_o(inact_read_i));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check_lvl(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_evt(input logic [1:0] got, input logic [1:0] exp);
        check_lvl({6'h0, got}, {6'h0, exp});
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Ends two edges after the flag lands, so callers may sample at once
    task automatic send(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(posedge clk_i);
        sample_valid_i <= 1'h1;
        sample_i <= '{x, y, z};
        @(posedge clk_i);
        sample_valid_i <= 1'h0;
        wt(3);
    endtask
    task automatic go(input mad_link_t lk, input logic [3:0] md);
        op_mode_i <= OPM_STANDBY;
        wt(2);
        link_mode_i <= lk;
        wt(2);
        op_mode_i <= md;
        @(posedge clk_i);
    endtask
    task automatic serve();
        svc_en <= 1'h1;
        svc_dly <= 4'($random(seed));
        wt(24);
        svc_en <= 1'h0;
        @(posedge clk_i);
    endtask
    function automatic logic [15:0] qv();
        qv = 16'($random(seed) % 40);
    endfunction
    always @(posedge clk_i) begin
        if ((act_flag_o && !act_q) || (inact_flag_o && !inact_q)) begin
            check_evt({act_flag_o && !act_q, inact_flag_o && !inact_q},
                (exp_q.size() > 0) ? exp_q.pop_front() : 2'h0);
        end
        act_q <= act_flag_o;
        inact_q <= inact_flag_o;
    end
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        wt(3);
        sys_rst_i <= 1'h0;
        go(MAD_LINK_DEFAULT, OPM_VERY_LOW_POWER);
        check_lvl(8'({act_armed_o, inact_armed_o}), 8'h02);
        send(16'h7FFF, 16'h8000, 16'h1000);
        check_lvl(8'({act_flag_o, inact_flag_o}), 8'h00);
        act_cfg_i <= '{1'h1, 1'h0, 3'h2, 16'h0064, 16'h0002};
        send(16'h7FFF, 16'h0000, 16'h7FFF);
        send(16'h0000, 16'h0065, 16'h0000);
        send(16'h0000, 16'hFF00, 16'h0000);
        send(16'h0000, 16'h0064, 16'h0000);
        send(16'h0000, 16'h0065, 16'h0000);
        send(16'h0000, 16'hFF9B, 16'h0000);
        exp_q.push_back(2'h2);
        send(16'h0000, 16'h0200, 16'h0000);
        send(16'h0000, 16'h0200, 16'h0000);
        check_lvl(8'({act_flag_o, motion_int_o}), 8'h03);
        serve();
        check_lvl(8'({act_flag_o, motion_int_o}), 8'h00);
        act_cfg_i <= '0;
        inact_cfg_i <= '{1'h1, 1'h0, 3'h7, 16'h0032, 16'h0001};
        send(qv(), 16'h0032, qv());
        send(qv(), qv(), 16'hFFCE);
        send(qv(), qv(), qv());
        exp_q.push_back(2'h1);
        send(qv(), qv(), qv());
        check_lvl(8'({inact_flag_o, motion_int_o}), 8'h02);
        serve();
        act_cfg_i <= '{1'h1, 1'h0, 3'h7, 16'h0064, 16'h0000};
        op_mode_i <= 4'h4;
        send(16'h0200, 16'h0200, 16'h0200);
        check_lvl(8'({act_flag_o, inact_flag_o}), 8'h00);
        inact_cfg_i <= '{1'h1, 1'h0, 3'h7, 16'h0032, 16'h0000};
        go(MAD_LINK_LINKED, OPM_HEART_SOUND);
        send(qv(), qv(), qv());
        exp_q.push_back(2'h2);
        send(16'h0200, qv(), qv());
        check_lvl(8'({act_armed_o, inact_armed_o}), 8'h00);
        serve();
        check_lvl(8'({act_armed_o, inact_armed_o}), 8'h01);
        send(16'h0200, qv(), qv());
        exp_q.push_back(2'h1);
        send(qv(), qv(), qv());
        serve();
        check_lvl(8'({act_armed_o, inact_armed_o}), 8'h02);
        go(MAD_LINK_LOOP, OPM_ULTRA_LOW_POWER);
        send(qv(), 16'h0200, qv());
        check_lvl(8'({act_flag_o, act_armed_o, inact_armed_o}), 8'h01);
        send(qv(), qv(), qv());
        check_lvl(8'({inact_flag_o, act_armed_o, inact_armed_o}), 8'h02);
        act_cfg_i <= '0;
        act_int_map_i <= 1'h0;
        inact_int_map_i <= 1'h1;
        inact_cfg_i <= '{1'h1, 1'h1, 3'h7, 16'h0032, 16'h0000};
        // Reserved link code behaves as default
        go(MAD_LINK_RSVD, OPM_VERY_LOW_POWER);
        send(16'h03E8, 16'h03E8, 16'h03E8);
        exp_q.push_back(2'h1);
        send(16'h03FC, 16'h03DE, 16'h03F2);
        check_lvl(8'(exp_q.size()), 8'h00);
        check_lvl(8'({inact_flag_o, motion_int_o}), 8'h03);
        report_and_stop();
    end
endmodule
bind mad_detector mad_detector_properties #(.AXES(AXES)) chk_u (.clk_i, .sys_rst_i, .op_mode_i,
    .link_mode_i, .act_cfg_i, .inact_cfg_i, .sample_valid_i, .sample_i, .act_read_i,
    .inact_read_i, .act_int_map_i, .inact_int_map_i, .act_flag_o, .inact_flag_o,
    .act_armed_o, .inact_armed_o, .motion_int_o);
`default_nettype wire
